// ### hdl/emb_pkg.sv
package emb_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int EMB_DATA_W = 16;
  localparam int EMB_ADDR_W = 11;
  localparam int EMB_ROWS = 128;
  localparam int EMB_ROW_AW = 7;
  localparam logic [2:0] EMB_ASPECT_MAX = 3'h4;

  // ----------------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------------
  localparam logic [11:0] EMB_CTRL_OFF = 12'h000;
  localparam logic [11:0] EMB_STATUS_OFF = 12'h004;
  localparam int EMB_MODE_LSB = 0;
  localparam int EMB_ASPECT_LSB = 2;
  localparam int EMB_OUTREG_BIT = 5;
  localparam int EMB_DEFDRV_BIT = 6;
  localparam int EMB_PAGE_ID_LSB = 8;
  localparam int EMB_PAGE_LAST_LSB = 12;
  localparam int EMB_ST_ADDR_LSB = 0;
  localparam int EMB_ST_VALID_BIT = 16;
  localparam int EMB_ST_DRIVE_BIT = 17;
  localparam logic [31:0] EMB_CTRL_RESET = 32'h0000_0020;

  typedef enum logic [1:0] {
    EMB_MODE_DUAL = 2'b00,
    EMB_MODE_SINGLE = 2'b01,
    EMB_MODE_CAM = 2'b10,
    EMB_MODE_ROM = 2'b11
  } emb_mode_t;

  // ----------------------------------------------------------------------
  // Aspect-ratio address arithmetic
  // ----------------------------------------------------------------------
  // Aspect n selects (128 << n) words of (16 >> n) bits inside one 128x16 array.
  function automatic logic [6:0] emb_row(input logic [10:0] addr, input logic [2:0] aspect);
    return 7'(addr >> aspect);
  endfunction

  function automatic logic [3:0] emb_lane_off(input logic [10:0] addr,
                                              input logic [2:0] aspect);
    logic [10:0] lane;
    logic [10:0] width;
    lane = addr & ((11'h001 << aspect) - 11'h001);
    width = 11'h010 >> aspect;
    return 4'(lane * width);
  endfunction

  function automatic logic [15:0] emb_width_mask(input logic [2:0] aspect);
    logic [4:0] width;
    width = 5'h10 >> aspect;
    return 16'((17'h0_0001 << width) - 17'h0_0001);
  endfunction

endpackage

// ### hdl/emb_ram_core.sv
`timescale 1ns/10ps
`default_nettype none
module emb_ram_core
  import emb_pkg::*;
(
  input wire logic pclk,
  input wire logic wr_pulse,
  input wire logic [EMB_ROW_AW-1:0] wr_row,
  input wire logic [EMB_DATA_W-1:0] wr_bits,
  input wire logic [EMB_DATA_W-1:0] wr_mask,
  input wire logic [EMB_ROW_AW-1:0] rd_row,
  output logic [EMB_DATA_W-1:0] rd_word,
  input wire logic [EMB_DATA_W-1:0] search_key,
  output logic [EMB_ADDR_W-1:0] search_addr,
  output logic search_hit
);

  // Array contents are not cleared by reset; only the pipeline registers are.
  logic [EMB_DATA_W-1:0] mem [0:EMB_ROWS-1];

  always_ff @(posedge pclk) begin
    if (wr_pulse) begin
      mem[wr_row] <= (mem[wr_row] & ~wr_mask) | (wr_bits & wr_mask);
    end
  end

  assign rd_word = mem[rd_row];

  // Lowest matching row wins, so duplicate words give a stable answer.
  always_comb begin
    search_hit = 1'b0;
    search_addr = '0;
    for (int i = EMB_ROWS - 1; i >= 0; i--) begin
      if (mem[i] == search_key) begin
        search_hit = 1'b1;
        search_addr = 11'(i);
      end
    end
  end

  cam_hit_a: assert property (@(posedge pclk)
    search_hit |-> mem[search_addr[EMB_ROW_AW-1:0]] == search_key)
    else $error("search address does not hold the key");

endmodule // emb_ram_core
`default_nettype wire

// ### hdl/emb_page_decode.sv
`timescale 1ns/10ps
`default_nettype none
module emb_page_decode #(
  parameter int PAGE_W = 2
) (
  input wire logic [PAGE_W-1:0] page,
  input wire logic [PAGE_W-1:0] page_id,
  input wire logic [PAGE_W-1:0] page_last,
  input wire logic default_drive,
  output logic line_oe_n
);

  // The default driver covers pages that no block owns, so the line never floats.
  always_comb begin
    line_oe_n = 1'b1;
    if (page == page_id) begin
      line_oe_n = 1'b0;
    end else if (default_drive && (page > page_last)) begin
      line_oe_n = 1'b0;
    end
  end

endmodule // emb_page_decode
`default_nettype wire

// ### hdl/emb_mem_block.sv
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Arrangements run from 128x16 to 2048x1, width halving as depth doubles.
// - Write inputs pass input registers, and read data may pass output registers.
// - In dual-port mode a write and a read are accepted in the same cycle.
// - The block times its own write strobe; users only meet clock setup and hold.
// - Wider words are parallel blocks on one address, each giving a slice.
// - A programmable page decoder enables the tri-state output for its own page, and for pages above page_last when default drive is set.
// - Eleven low address bits address the block; the upper bits feed the page decoder.
// - The tri-state control never lets two blocks drive the line, and leaves it floating for pages above page_last unless default drive is set.
// - The input clock registers write data, write request, read request and both addresses.
// - The output clock registers the read-data output stage and the match address and flag.
// - Input and output register groups have separate clock enables and asynchronous clears.
// - Input and output group registers clear asynchronously from a local, the global or the chip-wide reset; ctrl and prdata from presetn only.
// - Single-port mode uses one shared address, a write request and the two clock enables.
// - Content-addressable mode takes a data word and returns the address holding it.
module emb_mem_block
  import emb_pkg::*;
#(
  parameter int PAGE_W = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic global_aclr,
  input wire logic in_aclr,
  input wire logic out_aclr,
  input wire logic in_clken,
  input wire logic out_clken,
  input wire logic [EMB_ADDR_W+PAGE_W-1:0] wr_addr,
  input wire logic [EMB_DATA_W-1:0] wr_data,
  input wire logic wr_req,
  input wire logic [EMB_ADDR_W+PAGE_W-1:0] rd_addr,
  input wire logic read_request,
  output logic [EMB_DATA_W-1:0] rd_data,
  output logic [EMB_DATA_W-1:0] rd_line_out,
  output logic rd_line_oe_n,
  output logic [EMB_ADDR_W-1:0] match_addr,
  output logic match_valid
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (PAGE_W < 1 || PAGE_W > 4) begin : g_bad_page_w
    $error("PAGE_W must lie between 1 and 4");
  end

  // ----------------------------------------------------------------------
  // Clear tree
  // ----------------------------------------------------------------------
  logic in_clr_n;
  logic out_clr_n;

  // Either group can be cleared alone, so a flush of the output stage keeps writes intact.
  assign in_clr_n = presetn & ~global_aclr & ~in_aclr;
  assign out_clr_n = presetn & ~global_aclr & ~out_aclr;

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  logic [31:0] ctrl;
  logic apb_write;
  logic apb_mapped;
  logic [2:0] next_aspect;

  assign pready = 1'b1;
  assign apb_write = psel & penable & pwrite;
  assign apb_mapped = (paddr == EMB_CTRL_OFF) || (paddr == EMB_STATUS_OFF);
  assign pslverr = psel & penable & ~apb_mapped;

  // An aspect code above the largest arrangement is refused and the old one kept.
  assign next_aspect = (pwdata[EMB_ASPECT_LSB +: 3] > EMB_ASPECT_MAX) ?
                       ctrl[EMB_ASPECT_LSB +: 3] : pwdata[EMB_ASPECT_LSB +: 3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= EMB_CTRL_RESET;
    end else if (apb_write && paddr == EMB_CTRL_OFF) begin
      ctrl <= {pwdata[31:5], next_aspect, pwdata[1:0]};
    end
  end

  emb_mode_t mode;
  logic [2:0] aspect;
  logic out_reg_en;
  logic [PAGE_W-1:0] page_id;
  logic [PAGE_W-1:0] page_last;

  assign mode = emb_mode_t'(ctrl[EMB_MODE_LSB +: 2]);
  assign aspect = ctrl[EMB_ASPECT_LSB +: 3];
  assign out_reg_en = ctrl[EMB_OUTREG_BIT];
  assign page_id = ctrl[EMB_PAGE_ID_LSB +: PAGE_W];
  assign page_last = ctrl[EMB_PAGE_LAST_LSB +: PAGE_W];

  logic [31:0] status;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      if (paddr == EMB_CTRL_OFF) begin
        prdata <= ctrl;
      end else if (paddr == EMB_STATUS_OFF) begin
        prdata <= status;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Input register group
  // ----------------------------------------------------------------------
  logic [EMB_ADDR_W+PAGE_W-1:0] in_wr_addr;
  logic [EMB_ADDR_W+PAGE_W-1:0] in_rd_addr;
  logic [EMB_DATA_W-1:0] in_wr_data;
  logic in_wr_req;
  logic in_rd_req;

  always_ff @(posedge pclk or negedge in_clr_n) begin
    if (!in_clr_n) begin
      in_wr_addr <= '0;
      in_rd_addr <= '0;
      in_wr_data <= '0;
      in_wr_req <= 1'b0;
      in_rd_req <= 1'b0;
    end else if (in_clken) begin
      in_wr_addr <= wr_addr;
      in_rd_addr <= rd_addr;
      in_wr_data <= wr_data;
      in_wr_req <= wr_req;
      in_rd_req <= read_request;
    end
  end

  // ----------------------------------------------------------------------
  // Mode steering
  // ----------------------------------------------------------------------
  logic wr_allow;
  logic [EMB_ADDR_W+PAGE_W-1:0] eff_rd_addr;
  logic [EMB_ADDR_W-1:0] wr_low;
  logic [EMB_ADDR_W-1:0] rd_low;
  logic [PAGE_W-1:0] rd_page;

  always_comb begin
    unique case (mode)
      EMB_MODE_DUAL: begin
        wr_allow = 1'b1;
        eff_rd_addr = in_rd_addr;
      end
      EMB_MODE_SINGLE: begin
        wr_allow = 1'b1;
        eff_rd_addr = in_wr_addr;
      end
      EMB_MODE_CAM: begin
        wr_allow = 1'b1;
        eff_rd_addr = in_rd_addr;
      end
      EMB_MODE_ROM: begin
        wr_allow = 1'b0;
        eff_rd_addr = in_rd_addr;
      end
    endcase
  end

  // Only the low eleven bits reach the array; the rest choose the page.
  assign wr_low = in_wr_addr[EMB_ADDR_W-1:0];
  assign rd_low = eff_rd_addr[EMB_ADDR_W-1:0];
  assign rd_page = eff_rd_addr[EMB_ADDR_W +: PAGE_W];

  // ----------------------------------------------------------------------
  // Self-timed write strobe and array
  // ----------------------------------------------------------------------
  logic wr_pulse;
  logic [3:0] wr_off;
  logic [3:0] rd_off;
  logic [EMB_ROW_AW-1:0] wr_row;
  logic [EMB_ROW_AW-1:0] rd_row;
  logic [EMB_DATA_W-1:0] rd_word;
  logic [EMB_DATA_W-1:0] rd_slice;
  logic [EMB_ADDR_W-1:0] search_addr;
  logic search_hit;

  // The strobe is the registered request, gated off in ROM mode, so the user never
  // shapes a write enable against address and data timing.
  assign wr_pulse = in_wr_req & wr_allow;
  assign wr_off = emb_lane_off(wr_low, aspect);
  assign rd_off = emb_lane_off(rd_low, aspect);
  assign wr_row = emb_row(wr_low, aspect);
  assign rd_row = emb_row(rd_low, aspect);
  assign rd_slice = (rd_word >> rd_off) & emb_width_mask(aspect);

  emb_ram_core u_core (
    .pclk(pclk),
    .wr_pulse(wr_pulse),
    .wr_row(wr_row),
    .wr_bits(in_wr_data << wr_off),
    .wr_mask(emb_width_mask(aspect) << wr_off),
    .rd_row(rd_row),
    .rd_word(rd_word),
    .search_key(in_wr_data),
    .search_addr(search_addr),
    .search_hit(search_hit)
  );

  // ----------------------------------------------------------------------
  // Output register group
  // ----------------------------------------------------------------------
  logic [EMB_DATA_W-1:0] out_data;

  always_ff @(posedge pclk or negedge out_clr_n) begin
    if (!out_clr_n) begin
      out_data <= '0;
    end else if (out_clken && in_rd_req) begin
      out_data <= rd_slice;
    end
  end

  always_ff @(posedge pclk or negedge out_clr_n) begin
    if (!out_clr_n) begin
      match_addr <= '0;
      match_valid <= 1'b0;
    end else if (out_clken && mode == EMB_MODE_CAM) begin
      match_addr <= search_addr;
      match_valid <= search_hit;
    end
  end

  // Bypassing the output stage saves a cycle of latency at the cost of a longer path.
  assign rd_data = out_reg_en ? out_data : rd_slice;

  // ----------------------------------------------------------------------
  // Shared line driver
  // ----------------------------------------------------------------------
  // Each block of a wide word carries its own slice with no glue logic.
  assign rd_line_out = rd_data;

  emb_page_decode #(
    .PAGE_W(PAGE_W)
  ) u_page (
    .page(rd_page),
    .page_id(page_id),
    .page_last(page_last),
    .default_drive(ctrl[EMB_DEFDRV_BIT]),
    .line_oe_n(rd_line_oe_n)
  );

  always_comb begin
    status = 32'h0000_0000;
    status[EMB_ST_ADDR_LSB +: EMB_ADDR_W] = match_addr;
    status[EMB_ST_VALID_BIT] = match_valid;
    status[EMB_ST_DRIVE_BIT] = ~rd_line_oe_n;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  wr_strobe_a: assert property (@(posedge pclk) disable iff (!in_clr_n)
    (in_clken && wr_req) |=> (wr_pulse == (mode != EMB_MODE_ROM)))
    else $error("write request did not produce a write strobe");

  rom_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == EMB_MODE_ROM) |-> !wr_pulse)
    else $error("write strobe while writes are blocked");

  in_hold_a: assert property (@(posedge pclk) disable iff (!in_clr_n)
    !in_clken |=> $stable(in_wr_addr) && $stable(in_wr_data) && $stable(in_rd_req))
    else $error("input group moved without its clock enable");

  in_capture_a: assert property (@(posedge pclk) disable iff (!in_clr_n)
    in_clken |=> in_rd_addr == $past(rd_addr) && in_wr_req == $past(wr_req))
    else $error("input group missed a capture");

  out_hold_a: assert property (@(posedge pclk) disable iff (!out_clr_n)
    (out_reg_en && !out_clken) |=> (out_reg_en -> $stable(rd_data)))
    else $error("output stage moved without its clock enable");

  out_load_a: assert property (@(posedge pclk) disable iff (!out_clr_n)
    (out_clken && in_rd_req) |=> out_data == $past(rd_slice))
    else $error("output stage did not load read data");

  page_own_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_page == page_id) |-> !rd_line_oe_n)
    else $error("addressed page does not drive the line");

  page_other_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_page != page_id && rd_page <= page_last) |-> rd_line_oe_n)
    else $error("block drives a page it does not own");

  single_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == EMB_MODE_SINGLE) |-> rd_row == wr_row)
    else $error("single-port read and write addresses differ");

  cam_flag_a: assert property (@(posedge pclk) disable iff (!out_clr_n)
    (out_clken && mode == EMB_MODE_CAM) |=> match_valid == $past(search_hit))
    else $error("match flag does not follow the search");

  apb_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !apb_mapped) |-> pslverr && pready)
    else $error("unmapped access not flagged");

  // An error outside the access phase would be taken by a master as a failed idle cycle.
  apb_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && penable) |-> !pslverr)
    else $error("error flagged outside an access phase");

  // Read data is loaded in the setup cycle, so the access phase sees a settled word.
  ctrl_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr == EMB_CTRL_OFF) |=> prdata == $past(ctrl))
    else $error("control read returned a stale word");

  aspect_legal_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(aspect > EMB_ASPECT_MAX))
    else $error("aspect code names no arrangement");

  out_bypass_a: assert property (@(posedge pclk) disable iff (!presetn)
    !out_reg_en |-> rd_data == rd_slice)
    else $error("bypassed read data differs from the array");

  line_default_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl[EMB_DEFDRV_BIT] && rd_page > page_last) |-> !rd_line_oe_n)
    else $error("unowned page left the line floating");

  clear_all_a: assert property (@(posedge pclk) global_aclr |->
    !in_wr_req && !(|out_data) && !match_valid)
    else $error("global clear left a register set");

  status_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    status[EMB_ST_VALID_BIT] == match_valid &&
    status[EMB_ST_ADDR_LSB +: EMB_ADDR_W] == match_addr)
    else $error("status does not mirror the match result");

endmodule // emb_mem_block
`default_nettype wire

// ### sim/emb_user_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Fabric-side user logic
// ----------------------------------------------------------------------
module emb_user_model
  import emb_pkg::*;
#(
  parameter int PAGE_W = 2
) (
  input wire logic pclk,
  input wire logic [EMB_DATA_W-1:0] rd_data,
  input wire logic rd_line_oe_n,
  output logic [EMB_ADDR_W+PAGE_W-1:0] wr_addr,
  output logic [EMB_DATA_W-1:0] wr_data,
  output logic wr_req,
  output logic [EMB_ADDR_W+PAGE_W-1:0] rd_addr,
  output logic read_request
);
  initial begin
    wr_addr = '0;
    wr_data = '0;
    wr_req = 1'b0;
    rd_addr = '0;
    read_request = 1'b0;
  end

  // Requests change just after an edge and stand a full cycle, so the block's own
  // write strobe always sees settled inputs. Released lines show the inverse value
  // so that a stale capture cannot pass by luck.
  task automatic wr(input logic [EMB_ADDR_W+PAGE_W-1:0] a, input logic [15:0] d,
                    input logic req);
    @(posedge pclk);
    wr_addr <= a;
    wr_data <= d;
    wr_req <= req;
    @(posedge pclk);
    wr_req <= 1'b0;
    wr_data <= ~d;
    wr_addr <= ~a;
    @(posedge pclk);
    #1;
  endtask

  task automatic rd(input logic [EMB_ADDR_W+PAGE_W-1:0] a, input logic sp,
                    output logic [EMB_DATA_W-1:0] v, output logic oe_n);
    @(posedge pclk);
    read_request <= 1'b1;
    if (sp) begin
      wr_addr <= a;
      rd_addr <= ~a;
    end else begin
      rd_addr <= a;
    end
    @(posedge pclk);
    read_request <= 1'b0;
    rd_addr <= ~a;
    #1;
    oe_n = rd_line_oe_n;
    @(posedge pclk);
    #1;
    v = rd_data;
  endtask
endmodule // emb_user_model
`default_nettype wire

// ### sim/emb_mem_block_tb.sv
`timescale 1ns/10ps
`default_nettype none
module emb_mem_block_tb
  import emb_pkg::*;
;
  localparam int PW = 2;
  typedef logic [EMB_ADDR_W+PW-1:0] emb_uaddr_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic global_aclr = 1'b0;
  logic in_aclr = 1'b0;
  logic out_aclr = 1'b0;
  logic in_clken = 1'b1;
  logic out_clken = 1'b1;
  emb_uaddr_t wr_addr;
  emb_uaddr_t rd_addr;
  logic [15:0] wr_data;
  logic wr_req;
  logic read_request;
  logic [15:0] rd_data;
  logic [15:0] rd_line_out;
  logic rd_line_oe_n;
  logic [10:0] match_addr;
  logic match_valid;
  int err_total = 0;
  int n_checks = 0;
  logic [31:0] r;
  logic e;
  logic [15:0] v;
  logic [15:0] v2;
  logic oe;
  logic [15:0] m;

  always #2.5 pclk = ~pclk;

  emb_mem_block #(.PAGE_W(PW)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .global_aclr(global_aclr), .in_aclr(in_aclr),
    .out_aclr(out_aclr), .in_clken(in_clken), .out_clken(out_clken), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_req(wr_req), .rd_addr(rd_addr), .read_request(read_request),
    .rd_data(rd_data), .rd_line_out(rd_line_out), .rd_line_oe_n(rd_line_oe_n),
    .match_addr(match_addr), .match_valid(match_valid));

  emb_user_model #(.PAGE_W(PW)) mdl (.pclk(pclk), .rd_data(rd_data),
    .rd_line_oe_n(rd_line_oe_n), .wr_addr(wr_addr), .wr_data(wr_data), .wr_req(wr_req),
    .rd_addr(rd_addr), .read_request(read_request));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rv, output logic ev);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_total++;
      complete_run();
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ctrl(input logic [1:0] md, input logic [2:0] asp, input logic dd,
                      input logic [3:0] id, input logic [3:0] last);
    logic [31:0] w;
    w = (32'(md) << EMB_MODE_LSB) | (32'(asp) << EMB_ASPECT_LSB) | (32'h1 << EMB_OUTREG_BIT);
    w = w | (32'(dd) << EMB_DEFDRV_BIT) | (32'(id) << EMB_PAGE_ID_LSB);
    w = w | (32'(last) << EMB_PAGE_LAST_LSB);
    apb(1'b1, EMB_CTRL_OFF, w, r, e);
    apb(1'b0, EMB_CTRL_OFF, 32'h0, r, e);
    chk(r, w);
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    err_total++;
    complete_run();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(32'(rd_data), 32'h0);
    chk(32'(match_valid), 32'h0);
    apb(1'b0, EMB_CTRL_OFF, 32'h0, r, e);
    chk(r, EMB_CTRL_RESET);
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk(32'(e), 32'h1);
    chk(r, 32'h0);
    // Aspect code 5 names no arrangement, so only the mode field may change.
    apb(1'b1, EMB_CTRL_OFF, 32'h0000_0035, r, e);
    apb(1'b0, EMB_CTRL_OFF, 32'h0, r, e);
    chk(r, 32'h0000_0021);
    ctrl(EMB_MODE_DUAL, 3'h0, 1'b0, 4'h0, 4'h0);
    // Every row is filled first: the array is not cleared, and a search over
    // unwritten rows would give no defined answer.
    for (int i = 0; i < EMB_ROWS; i++) begin
      fork
        mdl.wr(emb_uaddr_t'(i), 16'h5A00 | 16'(i), 1'b1);
        mdl.rd(emb_uaddr_t'(i - 1), 1'b0, v, oe);
      join
      if (i > 0) chk(32'(v), 32'h0000_5A00 | 32'(i - 1));
    end
    mdl.wr(emb_uaddr_t'(14), 16'hFA12, 1'b1);
    ctrl(EMB_MODE_CAM, 3'h0, 1'b0, 4'h0, 4'h0);
    mdl.wr('0, 16'hFA12, 1'b0);
    chk(32'(match_addr), 32'h0000_000E);
    chk(32'(match_valid), 32'h1);
    mdl.wr('0, 16'h1234, 1'b0);
    chk(32'(match_valid), 32'h0);
    for (int a = 0; a <= 4; a++) begin
      ctrl(EMB_MODE_DUAL, 3'(a), 1'b0, 4'h0, 4'h0);
      m = 16'((17'h0_0001 << (16 >> a)) - 17'h0_0001);
      mdl.wr(emb_uaddr_t'(16), 16'hFFFF, 1'b1);
      mdl.wr(emb_uaddr_t'(17), 16'h0000, 1'b1);
      mdl.rd(emb_uaddr_t'(16), 1'b0, v, oe);
      mdl.rd(emb_uaddr_t'(17), 1'b0, v2, oe);
      chk(32'(v), 32'(m));
      chk(32'(v2), 32'h0);
    end
    ctrl(EMB_MODE_SINGLE, 3'h0, 1'b0, 4'h0, 4'h0);
    mdl.wr(emb_uaddr_t'(32), 16'hC3C3, 1'b1);
    mdl.rd(emb_uaddr_t'(32), 1'b1, v, oe);
    chk(32'(v), 32'h0000_C3C3);
    ctrl(EMB_MODE_ROM, 3'h0, 1'b0, 4'h0, 4'h0);
    mdl.wr(emb_uaddr_t'(32), 16'h0000, 1'b1);
    mdl.rd(emb_uaddr_t'(32), 1'b0, v, oe);
    chk(32'(v), 32'h0000_C3C3);
    // With the output stage frozen on C3C3, only the bypass path can show row 16.
    apb(1'b1, EMB_CTRL_OFF, 32'h0000_0001, r, e);
    out_clken <= 1'b0;
    mdl.rd(emb_uaddr_t'(16), 1'b1, v, oe);
    chk(32'(v), 32'h0000_FFFF);
    out_clken <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      ctrl(EMB_MODE_DUAL, 3'h0, k[2], 4'h1, 4'h1);
      mdl.rd(emb_uaddr_t'(((k % 4) << EMB_ADDR_W) | 5), 1'b0, v, oe);
      chk(32'(oe), 32'(!((k % 4) == 1 || (k[2] && (k % 4) > 1))));
      chk(32'(v), 32'h0000_5A05);
      chk(32'(rd_line_out), 32'h0000_5A05);
    end
    @(posedge pclk);
    out_clken <= 1'b0;
    mdl.rd(emb_uaddr_t'(6), 1'b0, v, oe);
    chk(32'(v), 32'h0000_5A05);
    @(posedge pclk);
    out_clken <= 1'b1;
    in_clken <= 1'b0;
    mdl.rd(emb_uaddr_t'(7), 1'b0, v, oe);
    chk(32'(v), 32'h0000_5A05);
    @(posedge pclk);
    in_clken <= 1'b1;
    out_aclr <= 1'b1;
    #1;
    chk(32'(rd_data), 32'h0);
    @(posedge pclk);
    out_aclr <= 1'b0;
    mdl.rd(emb_uaddr_t'(5), 1'b0, v, oe);
    chk(32'(v), 32'h0000_5A05);
    @(posedge pclk);
    global_aclr <= 1'b1;
    #1;
    chk(32'(rd_data), 32'h0);
    @(posedge pclk);
    global_aclr <= 1'b0;
    apb(1'b0, EMB_CTRL_OFF, 32'h0, r, e);
    chk(r, 32'h0000_1160);
    complete_run();
  end
endmodule // emb_mem_block_tb
`default_nettype wire
